// >>> pswc_pkg.sv
// Constants shared by both ends of the power-state and wake controller link.
// Assumes a single 40 MHz clock on both ends and a byte-addressed register map.
package pswc_pkg;

	// ==========================================================
	// Bus widths and register byte addresses
	localparam int unsigned PSWC_ADDR_W = 8;
	localparam int unsigned PSWC_DATA_W = 32;
	localparam logic [7:0] PSWC_ADDR_INTERRUPT_STATUS_REGISTER = 8'h58;
	localparam logic [7:0] PSWC_ADDR_INT_EN = 8'h5c;
	localparam logic [7:0] PSWC_ADDR_WAKE_TEST = 8'h64;
	localparam logic [7:0] PSWC_ADDR_PMC = 8'h84;
	localparam logic [7:0] PSWC_ADDR_PHY_CTRL = 8'ha0;
	localparam logic [7:0] PSWC_ADDR_PHY_MODE = 8'ha4;
	localparam logic [7:0] PSWC_ADDR_PHY_INT_SRC = 8'ha8;

	// ==========================================================
	// Field positions
	localparam int unsigned PSWC_PMC_READY_BIT = 0;
	localparam int unsigned PSWC_PMC_EVENT_EN_BIT = 1;
	localparam int unsigned PSWC_PMC_PULSE_BIT = 2;
	localparam int unsigned PSWC_PMC_WES_LSB = 4;
	localparam int unsigned PSWC_PMC_WF_EN_BIT = 8;
	localparam int unsigned PSWC_PMC_ENERGY_DETECT_WAKE_ENABLE_BIT = 9;
	localparam int unsigned PSWC_PMC_PSS_LSB = 12;
	localparam int unsigned PSWC_INT_PME_BIT = 4;
	localparam int unsigned PSWC_PHY_PD_BIT = 11;
	localparam int unsigned PSWC_PHY_EDPD_BIT = 13;
	localparam int unsigned PSWC_PHY_ENERGY_INT_BIT = 1;

	// ==========================================================
	// Field encodings and fixed values
	localparam logic [1:0] PSWC_PSS_FULL = 2'h0;
	localparam logic [1:0] PSWC_PSS_SLEEP1 = 2'h1;
	localparam logic [1:0] PSWC_PSS_SLEEP2 = 2'h2;
	localparam logic [1:0] PSWC_WES_NONE = 2'h0;
	localparam logic [1:0] PSWC_WES_ENERGY = 2'h1;
	localparam logic [1:0] PSWC_WES_FRAME = 2'h2;
	// Arbitrary pattern returned by the wake test register
	localparam logic [31:0] PSWC_WAKE_TEST_VALUE = 32'h5a5a_0f0f;

	// ==========================================================
	// Timing
	localparam int unsigned PSWC_CLK_PERIOD_NS = 25;
	localparam int unsigned PSWC_EVENT_PULSE_MS = 50;
	localparam int unsigned PSWC_EVENT_PULSE_CYCLES = PSWC_EVENT_PULSE_MS * 1000000 / PSWC_CLK_PERIOD_NS;
	localparam int unsigned PSWC_CNT_W = 22;

	// ==========================================================
	// State encodings
	typedef enum logic [2:0] {
		PSWC_FULL = 3'h1,
		PSWC_SLEEP1 = 3'h2,
		PSWC_SLEEP2 = 3'h4
	} pswc_pstate_e;

	typedef enum logic [1:0] {
		PSWC_H_IDLE = 2'h1,
		PSWC_H_WAIT = 2'h2
	} pswc_hstate_e;

endpackage : pswc_pkg

// >>> pswc_bus_if.sv
// Register bus between the host processor and the power-state controller.
// Assumes both ends share core_clk_in; strobes are one-cycle pulses.
`timescale 1ns/100ps
interface pswc_bus_if;
	import pswc_pkg::*;

	// ==========================================================
	// Host to device
	logic [PSWC_ADDR_W-1:0] addr;
	logic [PSWC_DATA_W-1:0] wdata;
	logic rd_stb;
	logic wr_stb;

	// ==========================================================
	// Device to host
	logic [PSWC_DATA_W-1:0] rdata;
	logic rd_valid;

	modport dev (
		input addr,
		input wdata,
		input rd_stb,
		input wr_stb,
		output rdata,
		output rd_valid
	);

	modport hst (
		output addr,
		output wdata,
		output rd_stb,
		output wr_stb,
		input rdata,
		input rd_valid
	);

endinterface : pswc_bus_if

// >>> pswc_device.sv
// Power-state and wake controller: full power plus two sleep states, clock gating,
// wake detection, event pin, interrupt status and the PHY power-down controls.
// Assumes the host on pswc_bus_if.dev and the wake-frame detector on the same clock.
`timescale 1ns/100ps
module pswc_device
	import pswc_pkg::*;
#(
	parameter int unsigned EVENT_PULSE_CYCLES = PSWC_EVENT_PULSE_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	pswc_bus_if.dev bus,
	input wire logic wake_frame_in,
	input wire logic line_energy_present_in,
	output logic event_out,
	output logic irq_out,
	output logic mac_clk_en_out,
	output logic host_clk_en_out,
	output logic int_clk_en_out,
	output logic rx_pm_en_out,
	output logic wake_detect_armed_out,
	output logic phy_powered_down_out,
	output logic phy_reset_out
);

	localparam logic [PSWC_CNT_W-1:0] PULSE_LOAD = PSWC_CNT_W'(EVENT_PULSE_CYCLES);

	// ==========================================================
	// State
	typedef struct packed {
		pswc_pstate_e pstate;
		logic read_seen;
		logic event_en;
		logic pulse_sel;
		logic [1:0] wes;
		logic wf_en;
		logic energy_detect_wake_enable;
		logic int_en;
		logic pme_sts;
		logic sig_q;
		logic [PSWC_CNT_W-1:0] pulse_cnt;
		logic phy_pd;
		logic phy_edpd;
		logic phy_energy_int;
		logic energy_q;
		logic phy_rst;
		logic [2:0] sync;
		logic energy;
		logic rd_valid;
		logic [31:0] rdata;
	} pswc_dev_s;

	pswc_dev_s r;
	pswc_dev_s next_r;

	logic ready;
	logic pme_sig;
	logic wr_ok;
	logic wr_pmc;
	logic [31:0] pmc_view;
	logic [31:0] rd_mux;

	// ==========================================================
	// Derived flags and register read view
	always_comb begin
		ready = (r.pstate == PSWC_FULL);
		// Internal event: source field qualified by the matching enable
		pme_sig = ((r.wes == PSWC_WES_FRAME) && r.wf_en) || ((r.wes == PSWC_WES_ENERGY) && r.energy_detect_wake_enable);
		wr_ok = bus.wr_stb && r.read_seen && ready;
		wr_pmc = wr_ok && (bus.addr == PSWC_ADDR_PMC);
		pmc_view = 32'h0;
		pmc_view[PSWC_PMC_READY_BIT] = ready;
		pmc_view[PSWC_PMC_EVENT_EN_BIT] = r.event_en;
		pmc_view[PSWC_PMC_PULSE_BIT] = r.pulse_sel;
		pmc_view[PSWC_PMC_WES_LSB +: 2] = r.wes;
		pmc_view[PSWC_PMC_WF_EN_BIT] = r.wf_en;
		pmc_view[PSWC_PMC_ENERGY_DETECT_WAKE_ENABLE_BIT] = r.energy_detect_wake_enable;
		pmc_view[PSWC_PMC_PSS_LSB +: 2] = (r.pstate == PSWC_SLEEP1) ? PSWC_PSS_SLEEP1 :
			(r.pstate == PSWC_SLEEP2) ? PSWC_PSS_SLEEP2 : PSWC_PSS_FULL;
		rd_mux = 32'h0;
		// Asleep, everything but the control register reads as zero
		if (bus.addr == PSWC_ADDR_PMC) begin
			rd_mux = pmc_view;
		end else if (ready) begin
			case (bus.addr)
				PSWC_ADDR_WAKE_TEST: begin
					rd_mux = PSWC_WAKE_TEST_VALUE;
				end
				PSWC_ADDR_INTERRUPT_STATUS_REGISTER: begin
					rd_mux[PSWC_INT_PME_BIT] = r.pme_sts;
				end
				PSWC_ADDR_INT_EN: begin
					rd_mux[PSWC_INT_PME_BIT] = r.int_en;
				end
				PSWC_ADDR_PHY_CTRL: begin
					rd_mux[PSWC_PHY_PD_BIT] = r.phy_pd;
				end
				PSWC_ADDR_PHY_MODE: begin
					rd_mux[PSWC_PHY_EDPD_BIT] = r.phy_edpd;
				end
				PSWC_ADDR_PHY_INT_SRC: begin
					rd_mux[PSWC_PHY_ENERGY_INT_BIT] = r.phy_energy_int;
				end
				default: begin
					rd_mux = 32'h0;
				end
			endcase
		end
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_r = r;
		next_r.phy_rst = 1'b0;
		// Energy pin: three stages, accepted when the last two agree
		next_r.sync = {r.sync[1:0], line_energy_present_in};
		if (r.sync[1] == r.sync[2]) begin
			next_r.energy = r.sync[2];
		end
		// Read port answers one cycle after the strobe
		next_r.rd_valid = bus.rd_stb;
		if (bus.rd_stb) begin
			next_r.rdata = rd_mux;
			next_r.read_seen = 1'b1;
		end
		// Register writes, only when awake and after a read
		if (wr_pmc) begin
			next_r.event_en = bus.wdata[PSWC_PMC_EVENT_EN_BIT];
			next_r.pulse_sel = bus.wdata[PSWC_PMC_PULSE_BIT];
			next_r.wes = r.wes & ~bus.wdata[PSWC_PMC_WES_LSB +: 2]; // Write one to clear
			next_r.wf_en = bus.wdata[PSWC_PMC_WF_EN_BIT];
			next_r.energy_detect_wake_enable = bus.wdata[PSWC_PMC_ENERGY_DETECT_WAKE_ENABLE_BIT];
			case (bus.wdata[PSWC_PMC_PSS_LSB +: 2])
				PSWC_PSS_SLEEP1: begin
					next_r.pstate = PSWC_SLEEP1;
				end
				PSWC_PSS_SLEEP2: begin
					next_r.pstate = PSWC_SLEEP2;
				end
				default: begin
					next_r.pstate = r.pstate;
				end
			endcase
		end
		if (wr_ok && (bus.addr == PSWC_ADDR_INT_EN)) begin
			next_r.int_en = bus.wdata[PSWC_INT_PME_BIT];
		end
		if (wr_ok && (bus.addr == PSWC_ADDR_PHY_CTRL)) begin
			next_r.phy_pd = bus.wdata[PSWC_PHY_PD_BIT];
			next_r.phy_rst = r.phy_pd && !bus.wdata[PSWC_PHY_PD_BIT];
		end
		if (wr_ok && (bus.addr == PSWC_ADDR_PHY_MODE)) begin
			next_r.phy_edpd = bus.wdata[PSWC_PHY_EDPD_BIT];
		end
		if (wr_ok && (bus.addr == PSWC_ADDR_PHY_INT_SRC) && bus.wdata[PSWC_PHY_ENERGY_INT_BIT]) begin
			next_r.phy_energy_int = 1'b0;
		end
		// Any write to the wake test register ends sleep; the bus is idle then
		if (bus.wr_stb && !ready && (bus.addr == PSWC_ADDR_WAKE_TEST)) begin
			next_r.pstate = PSWC_FULL;
			next_r.read_seen = 1'b0;
		end
		// Wake detection; level based, so carrier present at entry counts at once
		if ((r.pstate == PSWC_SLEEP1) && wake_frame_in) begin
			next_r.wes = PSWC_WES_FRAME;
		end
		if ((r.pstate == PSWC_SLEEP2) && r.energy) begin
			next_r.wes = PSWC_WES_ENERGY;
		end
		// Energy interrupt flag on energy arrival; set beats clear
		next_r.energy_q = r.energy;
		if (r.phy_edpd && r.energy && !r.energy_q) begin
			next_r.phy_energy_int = 1'b1;
		end
		// Interrupt status: write one clears only once the event is gone
		if (wr_ok && (bus.addr == PSWC_ADDR_INTERRUPT_STATUS_REGISTER) && bus.wdata[PSWC_INT_PME_BIT]) begin
			next_r.pme_sts = 1'b0;
		end
		if (pme_sig) begin
			next_r.pme_sts = 1'b1;
		end
		// Pulse timer starts on each new event
		next_r.sig_q = pme_sig;
		if (pme_sig && !r.sig_q) begin
			next_r.pulse_cnt = PULSE_LOAD;
		end else if (r.pulse_cnt != '0) begin
			next_r.pulse_cnt = r.pulse_cnt - PSWC_CNT_W'(1);
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '{pstate: PSWC_FULL, wes: PSWC_WES_NONE, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Outputs
	assign bus.rdata = r.rdata;
	assign bus.rd_valid = r.rd_valid;
	// Pin follows the event and its enable, so clearing the source field or the enable releases it; clearing the status bit does not
	assign event_out = pme_sig && r.event_en && (!r.pulse_sel || (r.pulse_cnt != '0));
	assign irq_out = r.pme_sts && r.int_en;
	assign mac_clk_en_out = (r.pstate == PSWC_FULL);
	assign host_clk_en_out = (r.pstate == PSWC_FULL);
	assign int_clk_en_out = (r.pstate != PSWC_SLEEP2);
	assign rx_pm_en_out = (r.pstate != PSWC_SLEEP2);
	assign wake_detect_armed_out = (r.pstate == PSWC_SLEEP1);
	// Management interface stays alive in both power-down modes
	assign phy_powered_down_out = r.phy_pd || (r.phy_edpd && !r.energy);
	assign phy_reset_out = r.phy_rst;

endmodule : pswc_device

// >>> pswc_host.sv
// Host end of the power-state controller bus: issues user reads and writes and
// keeps the access discipline the device relies on around sleep and wake.
// Assumes the device on pswc_bus_if.hst, same clock.
`timescale 1ns/100ps
module pswc_host
	import pswc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	pswc_bus_if.hst bus,
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_addr_in,
	input wire logic [31:0] cmd_wdata_in,
	output logic cmd_ready_out,
	output logic cmd_err_out,
	output logic rsp_valid_out,
	output logic [31:0] rsp_data_out,
	output logic ready_known_out
);

	// ==========================================================
	// State
	typedef struct packed {
		pswc_hstate_e st;
		logic auto_rd;
		logic auto_cur;
		logic ready_known;
		logic edpd_set;
		logic [7:0] addr;
		logic [31:0] wdata;
		logic rd_stb;
		logic wr_stb;
		logic err;
		logic rsp_valid;
		logic [31:0] rsp_data;
	} pswc_host_s;

	pswc_host_s r;
	pswc_host_s next_r;
	logic allowed;

	// ==========================================================
	// Access filter and sequencing
	always_comb begin
		next_r = r;
		next_r.rd_stb = 1'b0;
		next_r.wr_stb = 1'b0;
		next_r.err = 1'b0;
		next_r.rsp_valid = 1'b0;
		// Before readiness only a control register read or the wake write may go out
		allowed = r.ready_known || (!cmd_write_in && (cmd_addr_in == PSWC_ADDR_PMC)) ||
			(cmd_write_in && (cmd_addr_in == PSWC_ADDR_WAKE_TEST));
		// Second sleep only after the energy powerdown bit was set
		if (cmd_write_in && (cmd_addr_in == PSWC_ADDR_PMC) &&
			(cmd_wdata_in[PSWC_PMC_PSS_LSB +: 2] == PSWC_PSS_SLEEP2) && !r.edpd_set) begin
			allowed = 1'b0;
		end
		case (r.st)
			PSWC_H_IDLE: begin
				if (r.auto_rd) begin
					// Poll the control register after reset and after a wake write
					next_r.auto_rd = 1'b0;
					next_r.auto_cur = 1'b1;
					next_r.addr = PSWC_ADDR_PMC;
					next_r.rd_stb = 1'b1;
					next_r.st = PSWC_H_WAIT;
				end else if (cmd_valid_in && !allowed) begin
					next_r.err = 1'b1;
				end else if (cmd_valid_in && cmd_write_in) begin
					next_r.addr = cmd_addr_in;
					next_r.wdata = cmd_wdata_in;
					next_r.wr_stb = 1'b1;
					if (cmd_addr_in == PSWC_ADDR_WAKE_TEST) begin
						next_r.ready_known = 1'b0;
						next_r.auto_rd = 1'b1;
					end
					if (cmd_addr_in == PSWC_ADDR_PHY_MODE) begin
						next_r.edpd_set = cmd_wdata_in[PSWC_PHY_EDPD_BIT];
					end
					// Enables travel in the same word as the mode, so they land in the same cycle
					if ((cmd_addr_in == PSWC_ADDR_PMC) && (cmd_wdata_in[PSWC_PMC_PSS_LSB +: 2] != PSWC_PSS_FULL)) begin
						next_r.ready_known = 1'b0;
					end
				end else if (cmd_valid_in) begin
					next_r.auto_cur = 1'b0;
					next_r.addr = cmd_addr_in;
					next_r.rd_stb = 1'b1;
					next_r.st = PSWC_H_WAIT;
				end
			end
			PSWC_H_WAIT: begin
				if (bus.rd_valid) begin
					next_r.st = PSWC_H_IDLE;
					if (r.addr == PSWC_ADDR_PMC) begin
						next_r.ready_known = bus.rdata[PSWC_PMC_READY_BIT];
					end
					if (r.auto_cur) begin
						next_r.auto_rd = !bus.rdata[PSWC_PMC_READY_BIT];
					end else begin
						next_r.rsp_valid = 1'b1;
						next_r.rsp_data = bus.rdata;
					end
				end
			end
			default: begin
				next_r.st = PSWC_H_IDLE;
			end
		endcase
	end

	// ==========================================================
	// State register; first action after reset is a read
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '{st: PSWC_H_IDLE, auto_rd: 1'b1, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Outputs
	assign bus.addr = r.addr;
	assign bus.wdata = r.wdata;
	assign bus.rd_stb = r.rd_stb;
	assign bus.wr_stb = r.wr_stb;
	assign cmd_ready_out = (r.st == PSWC_H_IDLE) && !r.auto_rd;
	assign cmd_err_out = r.err;
	assign rsp_valid_out = r.rsp_valid;
	assign rsp_data_out = r.rsp_data;
	assign ready_known_out = r.ready_known;

endmodule : pswc_host

// >>> pswc_asserts.sv
// Bus-level checks for the link between the host end and the device end.
// Assumes it sees the pswc_bus_if signals plus the shared clock and reset.
`timescale 1ns/100ps
module pswc_asserts
	import pswc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [PSWC_ADDR_W-1:0] addr,
	input wire logic [PSWC_DATA_W-1:0] wdata,
	input wire logic rd_stb,
	input wire logic wr_stb,
	input wire logic [PSWC_DATA_W-1:0] rdata,
	input wire logic rd_valid
);
	// ==========================================================
	// Shadow state
	logic asleep;
	logic [1:0] sel;
	logic seen;

	// Rebuilt from bus traffic only, so a device bug cannot hide itself here
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			asleep <= 1'b0;
			sel <= 2'h0;
			seen <= 1'b0;
		end else if (wr_stb && asleep && addr == PSWC_ADDR_WAKE_TEST) begin
			asleep <= 1'b0;
			sel <= 2'h0;
			seen <= 1'b0; // Wake needs a fresh read
		end else if (wr_stb && seen && !asleep && addr == PSWC_ADDR_PMC && wdata[PSWC_PMC_PSS_LSB +: 2] != 2'h0) begin
			asleep <= 1'b1;
			sel <= wdata[PSWC_PMC_PSS_LSB +: 2];
		end else if (rd_stb) begin
			seen <= 1'b1;
		end
	end

	// ==========================================================
	// Properties
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);

	property p_rd_answer;
		rd_valid == $past(rd_stb);
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer not one cycle after request");

	property p_rdata_hold;
		!rd_valid |-> $stable(rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without an answer");

	property p_wake_test_value;
		!asleep && rd_stb && addr == PSWC_ADDR_WAKE_TEST |=> rdata == PSWC_WAKE_TEST_VALUE;
	endproperty
	a_wake_test_value: assert property (p_wake_test_value) else $error("wake test register read wrong");

	property p_sleep_notready;
		asleep && rd_stb && addr == PSWC_ADDR_PMC |=> !rdata[PSWC_PMC_READY_BIT];
	endproperty
	a_sleep_notready: assert property (p_sleep_notready) else $error("ready seen while asleep");

	property p_sleep_select;
		asleep && rd_stb && addr == PSWC_ADDR_PMC |=> rdata[PSWC_PMC_PSS_LSB +: 2] == $past(sel);
	endproperty
	a_sleep_select: assert property (p_sleep_select) else $error("state select not kept in sleep");

	property p_awake_ready;
		!asleep && rd_stb && addr == PSWC_ADDR_PMC |=> rdata[PSWC_PMC_READY_BIT] && rdata[PSWC_PMC_PSS_LSB +: 2] == PSWC_PSS_FULL;
	endproperty
	a_awake_ready: assert property (p_awake_ready) else $error("full power without ready or select 00");

	property p_host_sleep_rd;
		asleep && rd_stb |-> addr == PSWC_ADDR_PMC;
	endproperty
	a_host_sleep_rd: assert property (p_host_sleep_rd) else $error("host read other register while asleep");

	property p_host_sleep_wr;
		asleep && wr_stb |-> addr == PSWC_ADDR_WAKE_TEST;
	endproperty
	a_host_sleep_wr: assert property (p_host_sleep_wr) else $error("host wrote other register while asleep");

	property p_host_read_first;
		wr_stb && !asleep |-> seen;
	endproperty
	a_host_read_first: assert property (p_host_read_first) else $error("host wrote before reading");

endmodule : pswc_asserts

// >>> testbench.sv
// Self-checking bench: host and device ends joined on one bus, plus a bare device.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/100ps
module testbench;
	import pswc_pkg::*;
	logic clk, nrst, cmd_valid, cmd_write, wake_frame, energy, h_err;
	logic [7:0] cmd_addr;
	logic [31:0] cmd_wdata, h_q, b_q;
	wire logic [31:0] rsp_data;
	wire logic ev, irq, mac_en, host_en, int_en, rx_en, armed, phy_pd, phy_rst, c_rdy, c_err, r_vld, rdy_k;
	int n_fail, n_checks, ev_base, rst_base;
	// Counters start at zero here so the clocked counter process is their only writer
	int n_cyc = 0;
	int ev_cnt = 0;
	int rst_cnt = 0;

	// ==========================================================
	// Ends and checker
	pswc_bus_if bus();
	pswc_bus_if bus_b();
	pswc_device #(.EVENT_PULSE_CYCLES(20)) u_pswc_device(.core_clk_in(clk), .nrst_in(nrst), .bus(bus),
		.wake_frame_in(wake_frame), .line_energy_present_in(energy), .event_out(ev), .irq_out(irq),
		.mac_clk_en_out(mac_en), .host_clk_en_out(host_en), .int_clk_en_out(int_en), .rx_pm_en_out(rx_en),
		.wake_detect_armed_out(armed), .phy_powered_down_out(phy_pd), .phy_reset_out(phy_rst));
	pswc_host u_pswc_host(.core_clk_in(clk), .nrst_in(nrst), .bus(bus), .cmd_valid_in(cmd_valid),
		.cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata), .cmd_ready_out(c_rdy),
		.cmd_err_out(c_err), .rsp_valid_out(r_vld), .rsp_data_out(rsp_data), .ready_known_out(rdy_k));
	pswc_asserts u_pswc_asserts(.core_clk_in(clk), .nrst_in(nrst), .addr(bus.addr), .wdata(bus.wdata),
		.rd_stb(bus.rd_stb), .wr_stb(bus.wr_stb), .rdata(bus.rdata), .rd_valid(bus.rd_valid));
	// Bare device whose bus the bench drives, to break the access discipline on purpose
	pswc_device #(.EVENT_PULSE_CYCLES(20)) u_pswc_device_b(.core_clk_in(clk), .nrst_in(nrst), .bus(bus_b),
		.wake_frame_in(1'b0), .line_energy_present_in(1'b0), .event_out(), .irq_out(), .mac_clk_en_out(),
		.host_clk_en_out(), .int_clk_en_out(), .rx_pm_en_out(), .wake_detect_armed_out(),
		.phy_powered_down_out(), .phy_reset_out());

	// ==========================================================
	// Clock, cycle counters and hang guard
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		n_cyc <= n_cyc + 1;
		ev_cnt <= ev_cnt + int'(ev === 1'b1);
		rst_cnt <= rst_cnt + int'(phy_rst === 1'b1);
		if (n_cyc == 6000) begin
			n_fail = n_fail + 1;
			end_sim();
		end
	end

	// ==========================================================
	// Tasks
	task automatic end_sim();
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// User request on the host end; waits for ready, gathers answer or refusal
	task automatic hcmd(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		for (i = 0; i < 400 && c_rdy !== 1'b1; i++) @(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_addr = a;
		cmd_wdata = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		h_err = 1'b0;
		h_q = 'x;
		for (i = 0; i < 5; i++) begin
			if (c_err === 1'b1) h_err = 1'b1;
			if (r_vld === 1'b1) h_q = rsp_data;
			@(negedge clk);
		end
	endtask : hcmd

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		hcmd(1'b0, a, 32'h0);
		chk("host read", exp, h_q);
	endtask : rd

	// Raw one-cycle strobe on the bare device bus
	task automatic braw(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		bus_b.addr = a;
		bus_b.wdata = d;
		bus_b.rd_stb = !wr;
		bus_b.wr_stb = wr;
		@(negedge clk);
		bus_b.rd_stb = 1'b0;
		bus_b.wr_stb = 1'b0;
		b_q = 'x;
		for (i = 0; i < 3; i++) begin
			if (bus_b.rd_valid === 1'b1) b_q = bus_b.rdata;
			@(negedge clk);
		end
	endtask : braw

	// ==========================================================
	// Main sequence
	initial begin
		{n_fail, n_checks, ev_base, rst_base} = '0;
		{nrst, cmd_valid, cmd_write, wake_frame, energy} = '0;
		cmd_addr = 8'h00;
		cmd_wdata = 32'h0;
		{bus_b.rd_stb, bus_b.wr_stb, bus_b.addr, bus_b.wdata} = '0;
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		rd(PSWC_ADDR_PMC, 32'h0000_0001);
		rd(PSWC_ADDR_WAKE_TEST, PSWC_WAKE_TEST_VALUE);
		hcmd(1'b1, PSWC_ADDR_INT_EN, 32'h0000_0010);
		hcmd(1'b1, PSWC_ADDR_PMC, 32'h0000_1102);
		chk("sleep1 clocks", 32'h7, {mac_en, host_en, int_en, rx_en, armed});
		chk("host ready known in sleep", 32'h0, rdy_k);
		rd(PSWC_ADDR_PMC, 32'h0000_1102);
		hcmd(1'b0, PSWC_ADDR_INTERRUPT_STATUS_REGISTER, 32'h0);
		chk("asleep read refused", 32'h1, h_err);
		wake_frame = 1'b1;
		@(negedge clk);
		wake_frame = 1'b0;
		repeat (4) @(negedge clk);
		chk("pin and irq", 32'h3, {ev, irq});
		rd(PSWC_ADDR_PMC, 32'h0000_1122);
		hcmd(1'b1, PSWC_ADDR_WAKE_TEST, 32'h0);
		rd(PSWC_ADDR_PMC, 32'h0000_0123);
		chk("host ready known after wake", 32'h1, rdy_k);
		rd(PSWC_ADDR_INTERRUPT_STATUS_REGISTER, 32'h0000_0010);
		hcmd(1'b1, PSWC_ADDR_INTERRUPT_STATUS_REGISTER, 32'h0000_0010);
		rd(PSWC_ADDR_INTERRUPT_STATUS_REGISTER, 32'h0000_0010);
		hcmd(1'b1, PSWC_ADDR_PMC, 32'h0000_0122);
		chk("pin released", 32'h0, ev);
		hcmd(1'b1, PSWC_ADDR_INTERRUPT_STATUS_REGISTER, 32'h0000_0010);
		rd(PSWC_ADDR_INTERRUPT_STATUS_REGISTER, 32'h0);
		// Second sleep entered with energy already on the line
		energy = 1'b1;
		hcmd(1'b1, PSWC_ADDR_PHY_MODE, 32'h0000_2000);
		ev_base = ev_cnt;
		hcmd(1'b1, PSWC_ADDR_PMC, 32'h0000_2206);
		chk("sleep2 clocks", 32'h0, {mac_en, host_en, int_en, rx_en});
		repeat (40) @(negedge clk);
		chk("pulse width ok", 32'h1, (ev_cnt - ev_base) >= 19 && (ev_cnt - ev_base) <= 21);
		chk("pulse ended", 32'h0, ev);
		rd(PSWC_ADDR_PMC, 32'h0000_2216);
		hcmd(1'b1, PSWC_ADDR_WAKE_TEST, 32'h0);
		rd(PSWC_ADDR_PMC, 32'h0000_0217);
		energy = 1'b0;
		repeat (6) @(negedge clk);
		chk("phy down no energy", 32'h1, phy_pd);
		energy = 1'b1;
		repeat (6) @(negedge clk);
		chk("phy up on energy", 32'h0, phy_pd);
		rd(PSWC_ADDR_PHY_INT_SRC, 32'h0000_0002);
		hcmd(1'b1, PSWC_ADDR_PHY_MODE, 32'h0);
		// Energy powerdown now off, so a second-sleep request must be refused
		hcmd(1'b1, PSWC_ADDR_PMC, 32'h0000_2000);
		chk("sleep2 without powerdown refused", 32'h1, h_err);
		rd(PSWC_ADDR_PMC, 32'h0000_0217);
		hcmd(1'b1, PSWC_ADDR_PHY_CTRL, 32'h0000_0800);
		chk("phy powered down", 32'h1, phy_pd);
		rst_base = rst_cnt;
		hcmd(1'b1, PSWC_ADDR_PHY_CTRL, 32'h0);
		chk("phy reset pulses", 32'h1, rst_cnt - rst_base);
		chk("phy powered up", 32'h0, phy_pd);
		// Bare device: early write, blocked reads and writes in sleep
		braw(1'b1, PSWC_ADDR_PMC, 32'h0000_1000);
		braw(1'b0, PSWC_ADDR_PMC, 32'h0);
		chk("write before read", 32'h1, b_q);
		braw(1'b1, PSWC_ADDR_PMC, 32'h0000_1000);
		braw(1'b0, PSWC_ADDR_WAKE_TEST, 32'h0);
		chk("asleep other read", 32'h0, b_q);
		braw(1'b1, PSWC_ADDR_INT_EN, 32'h0000_0010);
		braw(1'b1, PSWC_ADDR_WAKE_TEST, 32'h0);
		braw(1'b0, PSWC_ADDR_PMC, 32'h0);
		chk("bare woke", 32'h1, b_q);
		braw(1'b0, PSWC_ADDR_INT_EN, 32'h0);
		chk("asleep write blocked", 32'h0, b_q);
		end_sim();
	end

endmodule : testbench
